// File: src/tsq_pkg.sv
/*
 pkg for the trace sequencer: register map, field layout, sizes, modes.
 assumes a plain register port and one 20 MHz clock.
*/
package tsq_pkg;
    localparam int CH_W      = 16;
    localparam int DEPTH     = 1024;
    localparam int AW        = 10;
    localparam int NSEQ      = 4;
    localparam int NRST      = 5;
    localparam int NQ        = 4;
    localparam int NCMP      = 16;
    localparam int NTERM     = 8;
    localparam int TW        = 3;

    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h01;
    localparam logic [7:0] A_SEQ     = 8'h02;
    localparam logic [7:0] A_RST     = 8'h03;
    localparam logic [7:0] A_QUAL0   = 8'h04;
    localparam logic [7:0] A_REMAIN  = 8'h08;
    localparam logic [7:0] A_DIFF    = 8'h09;
    localparam logic [7:0] A_RDADDR  = 8'h0A;
    localparam logic [7:0] A_RDDATA  = 8'h0B;
    localparam logic [7:0] A_TERM0   = 8'h10;
    localparam logic [7:0] A_CLINE0  = 8'h20;
    localparam logic [7:0] A_CVAL0   = 8'h30;
    localparam logic [7:0] A_CMASK0  = 8'h40;

    localparam int C_RUN    = 0;
    localparam int C_STOP   = 1;
    localparam int C_STORE  = 2;
    localparam int C_CLRIMG = 3;
    localparam int C_QEN    = 4;
    localparam int C_UNTIL  = 5;
    localparam int C_MODE   = 6;
    localparam int C_POS    = 8;
    localparam int C_NEXT   = 12;
    localparam int C_RSTEN  = 16;

    localparam logic [1:0] M_SINGLE = 2'b00;
    localparam logic [1:0] M_CONT   = 2'b01;
    localparam logic [1:0] M_LIST   = 2'b10;
    localparam logic [1:0] M_FULL   = 2'b11;

    localparam logic [1:0] P_START  = 2'b00;
    localparam logic [1:0] P_CENTER = 2'b01;
    localparam logic [1:0] P_END    = 2'b10;

    localparam logic [AW:0] POST_CENTER = 11'h01FF;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;

    typedef enum logic [2:0] {
        TSQ_IDLE  = 3'b000,
        TSQ_SEEK  = 3'b001,
        TSQ_POST  = 3'b010,
        TSQ_CMP   = 3'b011,
        TSQ_COPY  = 3'b100
    } tsq_state_t;
endpackage

// File: src/tsq_mem_if.sv
/*
 interface carrying trace and image memory port signals.
 assumes one clock shared by both ends.
*/
interface tsq_mem_if #(parameter int AW = 10, parameter int DW = 16);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: src/tsq_mem.sv
/*
 simple dual port memory, registered read data.
 assumes synchronous use on one clock.
*/
module tsq_mem #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic clk,
    tsq_mem_if.mem   port
);
    logic [DW-1:0] ram [0:(1<<AW)-1];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (port.we) begin
            ram[port.waddr] <= port.wdata;
        end
        rdata_r <= ram[port.raddr];
    end
    assign port.rdata = rdata_r;
endmodule

// File: src/tsq_top.sv
/*
 trace sequencer: trigger sequence with restart, store qualify, compare modes.
 assumes sampled states valid with sample_vld, synchronous to clk.
*/
// Functional notes
// - a restart term after partial progress returns to the first sequence step.
// - without restart terms, steps advance whenever the next term appears.
// - restart accepts the first term plus four more, ORed.
// - with qualification on, only qualifying states and the trigger state are written to trace memory.
// - each qualifier set ORs up to four terms.
// - with centre trigger the active step selects the qualifier set in use; start and end positions always use set 0.
// - centre trigger gives a qualifier set after each of the first three steps.
// - compare list of 16 entries addressed by line relative to trigger.
// - don't-care channels are excluded from an entry's equality check.
// - compare modes repeat traces until equal or until different.
// - stop in compare mode ends repeats, leaves single mode, keeps last trace.
// - full compare checks every stored line against the image.
// - storing an image copies the last trace, replacing the old image.
// - each differing compare-list line is flagged, matching lines are not.
// - the image is cleared on the clear command.
// - remaining qualified states to capture are reported during capture.
// - trigger is line zero, earlier states have negative line numbers.
// - each matched step arms the next; trace runs after all in order.
// - an immediate-successor step must match on the next sample, else fall back.
module tsq_top #(
    parameter int CH_W  = tsq_pkg::CH_W,
    parameter int AW    = tsq_pkg::AW
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [CH_W-1:0]  sample,
    input  wire logic             sample_vld,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    output logic                  busy,
    output logic                  trace_done
);
    localparam int NT = tsq_pkg::NTERM;
    localparam int NC = tsq_pkg::NCMP;

    tsq_mem_if #(.AW(AW), .DW(CH_W)) trc ();
    tsq_mem_if #(.AW(AW), .DW(CH_W)) img ();
    tsq_mem #(.AW(AW), .DW(CH_W)) u_trc (.clk(clk), .port(trc));
    tsq_mem #(.AW(AW), .DW(CH_W)) u_img (.clk(clk), .port(img));

    // term value in low half, care mask in high half
    logic [31:0]        term_r   [NT];
    logic [31:0]        ctrl_r, ctrl_nxt;
    logic [11:0]        seq_r;
    logic [14:0]        rst_r;
    logic [11:0]        qual_r   [4];
    logic [15:0]        cline_r  [NC];
    logic [CH_W-1:0]    cval_r   [NC];
    logic [CH_W-1:0]    cmask_r  [NC];
    logic [NC-1:0]      diff_r, diff_nxt;
    logic [AW-1:0]      rdaddr_r;
    logic               img_valid_r, img_valid_nxt;

    tsq_pkg::tsq_state_t st_r, st_nxt;
    logic [1:0]         step_r, step_nxt;
    logic               prev_hit_r, prev_hit_nxt;
    logic [AW-1:0]      wp_r, wp_nxt, trig_r, trig_nxt;
    logic [AW:0]        fill_r, fill_nxt, remain_r, remain_nxt;
    logic [AW-1:0]      cnt_r, cnt_nxt;
    logic               mism_r, mism_nxt;
    logic               stop_req_r, stop_req_nxt;
    logic               busy_r, done_r;
    logic [31:0]        rdata_nxt;

    function automatic logic term_hit(input logic [31:0] t, input logic [CH_W-1:0] s);
        term_hit = ((t[15:0] ^ s) & t[31:16]) == 16'h0000;
    endfunction

    function automatic logic set_hit(input logic [14:0] sel, input int n,
                                     input logic [CH_W-1:0] s);
        logic h;
        h = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (sel[i*3 +: 3] != 3'h0) begin
                h = h | term_hit(term_r[sel[i*3 +: 3]], s);
            end
        end
        set_hit = h;
    endfunction

    logic [NT-1:0] hits;
    always_comb begin
        for (int i = 0; i < NT; i++) begin
            hits[i] = term_hit(term_r[i], sample);
        end
    end

    logic [1:0] mode, pos;
    logic       run_cmd, stop_cmd, store_cmd, clr_cmd;
    assign mode      = ctrl_r[tsq_pkg::C_MODE +: 2];
    assign pos       = ctrl_r[tsq_pkg::C_POS +: 2];
    assign run_cmd   = reg_wr && reg_addr == tsq_pkg::A_CTRL && reg_wdata[tsq_pkg::C_RUN];
    assign stop_cmd  = reg_wr && reg_addr == tsq_pkg::A_CTRL && reg_wdata[tsq_pkg::C_STOP];
    assign store_cmd = reg_wr && reg_addr == tsq_pkg::A_CTRL && reg_wdata[tsq_pkg::C_STORE];
    assign clr_cmd   = reg_wr && reg_addr == tsq_pkg::A_CTRL && reg_wdata[tsq_pkg::C_CLRIMG];

    // sequence decode; step entries are 3 bit term selects, 0 never hits
    logic cur_hit, rst_hit, last_step, qual_ok, nxt_imm;
    always_comb begin
        cur_hit   = seq_r[step_r*3 +: 3] != 3'h0 && hits[seq_r[step_r*3 +: 3]];
        rst_hit   = set_hit(rst_r, tsq_pkg::NRST, sample);
        last_step = step_r == 2'd3 || seq_r[(step_r+2'd1)*3 +: 3] == 3'h0;
        nxt_imm   = ctrl_r[tsq_pkg::C_NEXT + step_r];
        // step picks qualifier set; sets 1..3 only for centre
        qual_ok   = set_hit({3'h0, qual_r[(pos == tsq_pkg::P_CENTER) ? step_r : 2'd0]},
                            tsq_pkg::NQ, sample);
    end

    always_comb begin
        st_nxt        = st_r;
        step_nxt      = step_r;
        prev_hit_nxt  = prev_hit_r;
        wp_nxt        = wp_r;
        trig_nxt      = trig_r;
        fill_nxt      = fill_r;
        remain_nxt    = remain_r;
        cnt_nxt       = cnt_r;
        mism_nxt      = mism_r;
        diff_nxt      = diff_r;
        stop_req_nxt  = stop_req_r | stop_cmd;
        img_valid_nxt = img_valid_r;
        ctrl_nxt      = ctrl_r;
        trc.we        = 1'b0;
        trc.waddr     = wp_r;
        trc.wdata     = sample;
        trc.raddr     = rdaddr_r;
        img.we        = 1'b0;
        img.waddr     = cnt_r;
        img.wdata     = trc.rdata;
        img.raddr     = cnt_r;
        if (reg_wr && reg_addr == tsq_pkg::A_CTRL) begin
            ctrl_nxt = reg_wdata & ~32'h0000_000F;
        end
        if (clr_cmd) begin
            img_valid_nxt = 1'b0;
        end
        unique case (st_r)
            tsq_pkg::TSQ_IDLE: begin
                if (run_cmd) begin
                    step_nxt = 2'd0; wp_nxt = '0; fill_nxt = '0;
                    diff_nxt = '0; mism_nxt = 1'b0; stop_req_nxt = stop_cmd;
                    remain_nxt = (AW+1)'(tsq_pkg::DEPTH);
                    st_nxt = tsq_pkg::TSQ_SEEK;
                end else if (store_cmd) begin
                    cnt_nxt = '0; trc.raddr = '0;
                    st_nxt = tsq_pkg::TSQ_COPY;
                end
            end
            tsq_pkg::TSQ_SEEK: if (sample_vld) begin
                // successor window spans idle cycles up to the next valid sample
                prev_hit_nxt = 1'b0;
                if (pos != tsq_pkg::P_START && (!ctrl_r[tsq_pkg::C_QEN] || qual_ok)) begin
                    trc.we = 1'b1; wp_nxt = wp_r + 1'b1;
                    if (fill_r != (AW+1)'(tsq_pkg::DEPTH)) fill_nxt = fill_r + 1'b1;
                end
                if (ctrl_r[tsq_pkg::C_RSTEN] && rst_hit && step_r != 2'd0) begin
                    step_nxt = 2'd0;
                end else if (cur_hit && (!nxt_imm || step_r == 2'd0 || prev_hit_r)) begin
                    if (last_step) begin
                        trc.we = 1'b1; trig_nxt = wp_r; wp_nxt = wp_r + 1'b1;
                        remain_nxt = (pos == tsq_pkg::P_END) ? '0 :
                                     (pos == tsq_pkg::P_CENTER) ? tsq_pkg::POST_CENTER :
                                     (AW+1)'(tsq_pkg::DEPTH - 1);
                        // end position passes post too, so the walk never reads
                        // the line being written at the trigger edge
                        st_nxt = tsq_pkg::TSQ_POST;
                        cnt_nxt = '0;
                    end else begin
                        step_nxt = step_r + 2'd1; prev_hit_nxt = 1'b1;
                    end
                end else if (nxt_imm && prev_hit_r && step_r != 2'd0) begin
                    step_nxt = step_r - 2'd1;
                end
            end
            tsq_pkg::TSQ_POST: begin
                if (remain_r == '0) begin
                    // prefetch line zero of both memories for the walk
                    cnt_nxt = '0; trc.raddr = '0; img.raddr = '0; st_nxt = tsq_pkg::TSQ_CMP;
                end else if (sample_vld && (!ctrl_r[tsq_pkg::C_QEN] || qual_ok)) begin
                    trc.we = 1'b1; wp_nxt = wp_r + 1'b1; remain_nxt = remain_r - 1'b1;
                end
            end
            tsq_pkg::TSQ_CMP: begin
                // reads run one line ahead, so line cnt_r stands on rdata now
                trc.raddr = AW'(cnt_r + 1'b1); img.raddr = AW'(cnt_r + 1'b1);
                cnt_nxt = cnt_r + 1'b1;
                if (mode == tsq_pkg::M_FULL && img_valid_r && trc.rdata != img.rdata) begin
                    mism_nxt = 1'b1;
                end
                for (int k = 0; k < NC; k++) begin
                    if (AW'(trig_r + cline_r[k][AW-1:0]) == cnt_r
                        && mode == tsq_pkg::M_LIST) begin
                        if (((trc.rdata ^ cval_r[k]) & cmask_r[k]) != '0) begin
                            diff_nxt[k] = 1'b1; mism_nxt = 1'b1;
                        end
                    end
                end
                if (cnt_r == '1) begin
                    st_nxt = tsq_pkg::TSQ_IDLE;
                    if (mode == tsq_pkg::M_CONT ||
                        (mode[1] && (ctrl_r[tsq_pkg::C_UNTIL] ? !mism_nxt : mism_nxt)
                         == 1'b0)) begin
                        if (!stop_req_r && !stop_cmd) begin
                            st_nxt = tsq_pkg::TSQ_SEEK; step_nxt = 2'd0;
                            wp_nxt = '0; fill_nxt = '0; diff_nxt = '0; mism_nxt = 1'b0;
                            remain_nxt = (AW+1)'(tsq_pkg::DEPTH);
                        end else if (mode[1]) begin
                            // stop leaves single mode, trace kept
                            ctrl_nxt[tsq_pkg::C_MODE +: 2] = tsq_pkg::M_SINGLE;
                        end
                    end
                end
            end
            tsq_pkg::TSQ_COPY: begin
                trc.raddr = AW'(cnt_r + 1'b1);
                img.we = 1'b1;
                img.waddr = cnt_r;
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == '1) begin
                    img_valid_nxt = 1'b1; st_nxt = tsq_pkg::TSQ_IDLE;
                end
            end
            default: st_nxt = tsq_pkg::TSQ_IDLE;
        endcase
        if (stop_cmd && st_r == tsq_pkg::TSQ_SEEK && !mode[1] && mode != tsq_pkg::M_CONT) begin
            st_nxt = tsq_pkg::TSQ_IDLE;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_addr)
            tsq_pkg::A_CTRL:   rdata_nxt = ctrl_r;
            tsq_pkg::A_STATUS: rdata_nxt = {24'h0000_00, 2'b00, img_valid_r, mism_r,
                                            step_r, st_r != tsq_pkg::TSQ_IDLE, 1'b0};
            tsq_pkg::A_SEQ:    rdata_nxt = {20'h0_0000, seq_r};
            tsq_pkg::A_RST:    rdata_nxt = {17'h0_0000, rst_r};
            tsq_pkg::A_REMAIN: rdata_nxt = {21'h00_0000, remain_r};
            tsq_pkg::A_DIFF:   rdata_nxt = {16'h0000, diff_r};
            tsq_pkg::A_RDADDR: rdata_nxt = {22'h00_0000, rdaddr_r};
            // lines before trigger read back as negative offsets (two's complement)
            tsq_pkg::A_RDDATA: rdata_nxt = {6'h00, AW'(rdaddr_r - trig_r), trc.rdata};
            default: begin
                if (reg_addr[7:4] == 4'h1 && reg_addr[3] == 1'b0)
                    rdata_nxt = term_r[reg_addr[2:0]];
                else if (reg_addr[7:2] == 6'h01)
                    rdata_nxt = {20'h0_0000, qual_r[reg_addr[1:0]]};
                else if (reg_addr[7:4] == 4'h2)
                    rdata_nxt = {16'h0000, cline_r[reg_addr[3:0]]};
                else if (reg_addr[7:4] == 4'h3)
                    rdata_nxt = {16'h0000, cval_r[reg_addr[3:0]]};
                else if (reg_addr[7:4] == 4'h4)
                    rdata_nxt = {16'h0000, cmask_r[reg_addr[3:0]]};
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= tsq_pkg::CTRL_RST; seq_r <= '0; rst_r <= '0; rdaddr_r <= '0;
            for (int i = 0; i < NT; i++) term_r[i] <= '0;
            for (int i = 0; i < 4; i++) qual_r[i] <= '0;
            for (int i = 0; i < NC; i++) begin
                cline_r[i] <= '0; cval_r[i] <= '0; cmask_r[i] <= '0;
            end
            st_r <= tsq_pkg::TSQ_IDLE; step_r <= '0; prev_hit_r <= 1'b0;
            wp_r <= '0; trig_r <= '0; fill_r <= '0; remain_r <= '0; cnt_r <= '0;
            mism_r <= 1'b0; diff_r <= '0; stop_req_r <= 1'b0; img_valid_r <= 1'b0;
            reg_rdata <= '0; busy <= 1'b0; trace_done <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt; st_r <= st_nxt; step_r <= step_nxt;
            prev_hit_r <= prev_hit_nxt; wp_r <= wp_nxt; trig_r <= trig_nxt;
            fill_r <= fill_nxt; remain_r <= remain_nxt; cnt_r <= cnt_nxt;
            mism_r <= mism_nxt; diff_r <= diff_nxt; stop_req_r <= stop_req_nxt;
            img_valid_r <= img_valid_nxt;
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
            busy <= st_nxt != tsq_pkg::TSQ_IDLE;
            trace_done <= st_r == tsq_pkg::TSQ_CMP && cnt_r == '1;
            if (reg_wr) begin
                if (reg_addr == tsq_pkg::A_SEQ) seq_r <= reg_wdata[11:0];
                if (reg_addr == tsq_pkg::A_RST) rst_r <= reg_wdata[14:0];
                if (reg_addr == tsq_pkg::A_RDADDR) rdaddr_r <= reg_wdata[AW-1:0];
                if (reg_addr[7:4] == 4'h1 && reg_addr[3] == 1'b0)
                    term_r[reg_addr[2:0]] <= reg_wdata;
                if (reg_addr[7:2] == 6'h01) qual_r[reg_addr[1:0]] <= reg_wdata[11:0];
                if (reg_addr[7:4] == 4'h2) cline_r[reg_addr[3:0]] <= reg_wdata[15:0];
                if (reg_addr[7:4] == 4'h3) cval_r[reg_addr[3:0]] <= reg_wdata[15:0];
                if (reg_addr[7:4] == 4'h4) cmask_r[reg_addr[3:0]] <= reg_wdata[15:0];
            end
        end
    end
endmodule

// File: test/tsq_props.sv
/*
 port-level assertions and covers for tsq_top.
 assumes the bind below; sees only the top ports.
*/
module tsq_props #(
    parameter int CH_W = 16,
    parameter int AW   = 10
) (
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic [CH_W-1:0] sample,
    input wire logic            sample_vld,
    input wire logic [7:0]      reg_addr,
    input wire logic [31:0]     reg_wdata,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [31:0]     reg_rdata,
    input wire logic            busy,
    input wire logic            trace_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_diff_width: assert property (
        reg_rd && reg_addr == tsq_pkg::A_DIFF |=> reg_rdata[31:16] == 16'h0000)
        else $error("flags beyond sixteen entries");
    a_remain_bound: assert property (
        reg_rd && reg_addr == tsq_pkg::A_REMAIN |=> reg_rdata <= 32'h0000_0400)
        else $error("remaining count above depth");
    a_done_pulse: assert property (trace_done |=> !trace_done)
        else $error("done longer than one cycle");
    a_done_busy: assert property (trace_done |-> $past(busy))
        else $error("done without a trace");
    a_run_starts: assert property (
        reg_wr && reg_addr == tsq_pkg::A_CTRL && reg_wdata[tsq_pkg::C_RUN] && !busy
        |-> ##[1:2] busy)
        else $error("run did not start");
    a_idle_holds: assert property (
        !busy && !reg_wr && !$past(reg_wr) |=> !busy)
        else $error("left idle without a command");

    c_done: cover property (trace_done);
    c_unmapped: cover property (reg_rd && reg_addr == 8'hFF);
    c_remain: cover property (reg_rd && reg_addr == tsq_pkg::A_REMAIN && busy);
endmodule

bind tsq_top tsq_props #(.CH_W(CH_W), .AW(AW)) tsq_props_inst (
    .clk(clk), .resetn(resetn), .sample(sample), .sample_vld(sample_vld),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .busy(busy), .trace_done(trace_done));

// File: test/tsq_probe_model.sv
/*
 model of the probed state lines of the target.
 assumes put is called right after a rising edge.
*/
module tsq_probe_model #(
    parameter int CH_W = 16
) (
    input  wire logic            clk,
    output logic      [CH_W-1:0] sample,
    output logic                 sample_vld
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sample     = '0;
        sample_vld = 1'b0;
    end
    // idle lines show the inverse so a stale state never matches
    task automatic put(input logic [CH_W-1:0] v);
        sample     <= v;
        sample_vld <= 1'b1;
        @(posedge clk);
        sample     <= ~v;
        sample_vld <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// File: test/tb_trace_sequencer_store_qualify_compare.sv
/*
 bench for tsq_top: sequencing, restart, qualify, image, list compare.
 assumes the probe model and the bound checker.
*/
module tb_trace_sequencer_store_qualify_compare;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        resetn;
    logic [15:0] sample;
    logic        sample_vld;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        busy;
    logic        trace_done;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          dones     = 0;
    logic [31:0] r1;
    logic [31:0] r2;

    tsq_top tsq_top_inst (.clk(clk), .resetn(resetn), .sample(sample),
        .sample_vld(sample_vld), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
        .trace_done(trace_done));
    tsq_probe_model tsq_probe_model_inst (.clk(clk), .sample(sample),
        .sample_vld(sample_vld));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // five traces plus two copies need about 16000 cycles
    always @(posedge clk) begin
        cyc++;
        if (trace_done === 1'b1)
            dones++;
        if (cyc == 30000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d & m, exp);
    endtask
    task automatic put(input logic [15:0] v);
        tsq_probe_model_inst.put(v);
    endtask
    task automatic trig;
        for (int i = 1; i < 5; i++)
            put(16'(i));
    endtask
    task automatic fill(input logic [15:0] v, input logic [15:0] s);
        int d0;
        d0 = dones;
        for (int i = 0; i < 2000 && dones == d0; i++)
            put(v + s * 16'(i));
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(posedge clk);
    endtask

    initial begin
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rdc(tsq_pkg::A_CTRL, 32'hFFFF_FFFF, tsq_pkg::CTRL_RST);
        rdc(tsq_pkg::A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc(8'hFF, 32'hFFFF_FFFF, 32'h0000_0000);
        // term k matches state k on every channel
        for (int k = 1; k < 7; k++)
            wr(tsq_pkg::A_TERM0 + 8'(k), {16'hFFFF, 16'(k)});
        wr(tsq_pkg::A_SEQ, 32'h0000_08D1);
        wr(tsq_pkg::A_RST, 32'h0000_5000);
        wr(tsq_pkg::A_CTRL, 32'h0001_0001);
        put(16'h0001);
        put(16'h0002);
        rdc(tsq_pkg::A_STATUS, 32'h0000_000C, 32'h0000_0008);
        put(16'h0005);
        rdc(tsq_pkg::A_STATUS, 32'h0000_000C, 32'h0000_0000);
        put(16'h0003);
        put(16'h0004);
        rdc(tsq_pkg::A_STATUS, 32'h0000_000E, 32'h0000_0002);
        trig();
        rd(tsq_pkg::A_REMAIN, r1);
        repeat (5) put(16'h0007);
        rd(tsq_pkg::A_REMAIN, r2);
        chk(r1 - r2, 32'h0000_0005);
        fill(16'h0100, 16'h0001);
        wait_idle();
        wr(tsq_pkg::A_RDADDR, 32'h0000_0000);
        rdc(tsq_pkg::A_RDDATA, 32'h03FF_FFFF, 32'h0000_0004);
        wr(tsq_pkg::A_RDADDR, 32'h0000_0001);
        rdc(tsq_pkg::A_RDDATA, 32'h03FF_FFFF, 32'h0001_0007);
        wr(tsq_pkg::A_CTRL, 32'h0000_0004);
        wait_idle();
        rdc(tsq_pkg::A_STATUS, 32'h0000_0020, 32'h0000_0020);
        wr(tsq_pkg::A_CTRL, 32'h0000_0008);
        rdc(tsq_pkg::A_STATUS, 32'h0000_0020, 32'h0000_0000);
        // qualifier in the fourth slot of every set, restart off
        for (int k = 0; k < 4; k++)
            wr(tsq_pkg::A_QUAL0 + 8'(k), 32'h0000_0C00);
        wr(tsq_pkg::A_CTRL, 32'h0000_0011);
        put(16'h0001);
        put(16'h0005);
        put(16'h0002);
        put(16'h0003);
        put(16'h0004);
        rd(tsq_pkg::A_REMAIN, r1);
        put(16'h0006);
        put(16'h0009);
        put(16'h0006);
        put(16'h0009);
        rd(tsq_pkg::A_REMAIN, r2);
        chk(r1 - r2, 32'h0000_0002);
        fill(16'h0006, 16'h0000);
        wait_idle();
        // step 1 must follow step 0 at once; a stray state sends it back
        wr(tsq_pkg::A_CTRL, 32'h0000_2001);
        put(16'h0001);
        put(16'h0006);
        rdc(tsq_pkg::A_STATUS, 32'h0000_000C, 32'h0000_0000);
        put(16'h0001);
        put(16'h0002);
        rdc(tsq_pkg::A_STATUS, 32'h0000_000C, 32'h0000_0008);
        wr(tsq_pkg::A_CTRL, 32'h0000_0002);
        rdc(tsq_pkg::A_STATUS, 32'h0000_0002, 32'h0000_0000);
        // entry 1 differs only on channels marked as ignored
        wr(tsq_pkg::A_CLINE0 + 8'h01, 32'h0000_0001);
        wr(tsq_pkg::A_CLINE0 + 8'h02, 32'h0000_0001);
        wr(tsq_pkg::A_CVAL0, 32'h0000_0004);
        wr(tsq_pkg::A_CVAL0 + 8'h01, 32'h0000_0BAD);
        wr(tsq_pkg::A_CVAL0 + 8'h02, 32'h0000_0BAD);
        wr(tsq_pkg::A_CMASK0, 32'h0000_FFFF);
        wr(tsq_pkg::A_CMASK0 + 8'h02, 32'h0000_FFFF);
        wr(tsq_pkg::A_CTRL, 32'h0001_0081);
        trig();
        fill(16'h0100, 16'h0001);
        wait_idle();
        rdc(tsq_pkg::A_DIFF, 32'h0000_FFFF, 32'h0000_0004);
        rdc(tsq_pkg::A_STATUS, 32'h0000_0010, 32'h0000_0010);
        chk({31'h0000_0000, busy}, 32'h0000_0000);
        // full compare: only the last line differs, stop arrives mid trace
        wr(tsq_pkg::A_CTRL, 32'h0000_0004);
        wait_idle();
        wr(tsq_pkg::A_CTRL, 32'h0000_00E1);
        trig();
        wr(tsq_pkg::A_CTRL, 32'h0000_00E2);
        for (int i = 0; i < 1023; i++)
            put((i == 1022) ? 16'h0BAD : 16'h0100 + 16'(i));
        wait_idle();
        rdc(tsq_pkg::A_CTRL, 32'h0000_00C0, 32'h0000_0000);
        rdc(tsq_pkg::A_STATUS, 32'h0000_0012, 32'h0000_0010);
        // trigger at the end: the state before it reads back as line -1
        wr(tsq_pkg::A_CTRL, 32'h0000_0201);
        trig();
        wait_idle();
        wr(tsq_pkg::A_RDADDR, 32'h0000_0002);
        rdc(tsq_pkg::A_RDDATA, 32'h03FF_FFFF, 32'h03FF_0003);
        summarize();
    end
endmodule
